// ### rtl/tdbc_pkg.sv
package tdbc_pkg;

   localparam int          ADDR_W           = 8;
   localparam int          DATA_W           = 32;
   localparam int          VAL_W            = 16;

   localparam logic [7:0]  FIRST_CTRL_OFS   = 8'h00;
   localparam logic [7:0]  CH3_VALUE_OFS    = 8'h40;
   localparam logic [7:0]  INPUT_REMAP_OFS  = 8'h50;
   localparam logic [7:0]  DMA_CFG_OFS      = 8'he0;
   localparam logic [7:0]  DMA_WINDOW_OFS   = 8'he4;
   localparam logic [7:0]  FILTER_CFG_OFS   = 8'hfc;

   localparam logic [31:0] REG_RESET        = 32'h00000000;

   localparam int          START_LSB        = 0;
   localparam int          START_MSB        = 4;
   localparam int          LENGTH_LSB       = 8;
   localparam int          LENGTH_MSB       = 12;
   localparam int          SOURCE_LSB       = 0;
   localparam int          SOURCE_MSB       = 1;
   localparam int          SKIP_BIT         = 1;

   localparam logic [4:0]  LENGTH_MAX       = 5'h11;

   localparam logic [1:0]  SRC_PIN          = 2'h0;
   localparam logic [1:0]  SRC_LOW_XTAL     = 2'h1;
   localparam logic [1:0]  SRC_HIGH_XTAL128 = 2'h2;
   localparam logic [1:0]  SRC_CLK_OUT_SEL  = 2'h3;
   localparam int          NUM_SOURCES      = 4;

   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;
   localparam logic [3:0]  FULL_STROBE      = 4'hf;

endpackage

// ### rtl/tdbc_regs.sv
// Operation
// - Input mode: capture value shown, writes blocked.
// - Output mode: value compared against running counter.
// - Shadow enabled: active compare loads on update.
// - Burst touches length field plus one registers.
// - Burst start is first control plus four times field.
// - Each window access targets four bytes higher.
// - Window access redirected to start plus four index.
// - Hardware steps index from zero to length.
// - Two-bit field selects channel 0 input source.
// - Skip bit discards writes equal to current value.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
module tdbc_regs
   import tdbc_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic [31:0]        s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [31:0]        s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic               channel3InputMode,
   input  wire logic               shadowEnable,
   input  wire logic               updateEvent,
   input  wire logic               captureEvent,
   input  wire logic [15:0]        counterValue,
   input  wire logic               pinInputChannelZero,
   input  wire logic               lowSpeedCrystalClock,
   input  wire logic               highSpeedCrystalDiv128,
   input  wire logic               clockOutputZeroSelection,
   output logic [15:0]             compareValue,
   output logic                    compareMatch,
   output logic                    channel0Input
);

   logic                 awHeld_r, awHeld_nxt;
   logic [ADDR_W-1:0]    awAddr_r, awAddr_nxt;
   logic                 wHeld_r, wHeld_nxt;
   logic [31:0]          wData_r, wData_nxt;
   logic [3:0]           wStrb_r, wStrb_nxt;
   logic                 arHeld_r, arHeld_nxt;
   logic [ADDR_W-1:0]    arAddr_r, arAddr_nxt;
   logic                 awReady_r, wReady_r, arReady_r;
   logic                 bValid_r, bValid_nxt;
   logic [1:0]           bResp_r, bResp_nxt;
   logic                 rValid_r, rValid_nxt;
   logic [1:0]           rResp_r, rResp_nxt;
   logic [31:0]          rData_r, rData_nxt;
   logic [VAL_W-1:0]     ch3Value_r, ch3Value_nxt;
   logic [VAL_W-1:0]     activeCompare_r, activeCompare_nxt;
   logic [4:0]           burstStart_r, burstStart_nxt;
   logic [4:0]           burstLength_r, burstLength_nxt;
   logic [4:0]           xferIndex_r, xferIndex_nxt;
   logic [1:0]           inputSource_r, inputSource_nxt;
   logic                 skipEqual_r, skipEqual_nxt;
   logic                 compareMatch_r, compareMatch_nxt;
   logic                 channel0Input_r;
   logic                 doWrite, doRead;
   logic [ADDR_W-1:0]    writeTarget, readTarget;
   logic [NUM_SOURCES-1:0] srcStable;
   logic [NUM_SOURCES-1:0] srcRaw;

   // An access to the window is steered to the start register plus the
   // current transfer index; the sum cannot reach the window itself.
   function automatic logic [ADDR_W-1:0] resolve_target(
      input logic [ADDR_W-1:0] addr,
      input logic [4:0]        start,
      input logic [4:0]        index
   );
      logic [5:0] slot;
      slot = {1'b0, start} + {1'b0, index};
      if (addr == DMA_WINDOW_OFS) begin
         resolve_target = FIRST_CTRL_OFS + {slot, 2'b00};
      end else begin
         resolve_target = addr;
      end
   endfunction

   always_comb begin
      awHeld_nxt        = awHeld_r;
      awAddr_nxt        = awAddr_r;
      wHeld_nxt         = wHeld_r;
      wData_nxt         = wData_r;
      wStrb_nxt         = wStrb_r;
      arHeld_nxt        = arHeld_r;
      arAddr_nxt        = arAddr_r;
      bValid_nxt        = bValid_r;
      bResp_nxt         = bResp_r;
      rValid_nxt        = rValid_r;
      rResp_nxt         = rResp_r;
      rData_nxt         = rData_r;
      ch3Value_nxt      = ch3Value_r;
      activeCompare_nxt = activeCompare_r;
      burstStart_nxt    = burstStart_r;
      burstLength_nxt   = burstLength_r;
      xferIndex_nxt     = xferIndex_r;
      inputSource_nxt   = inputSource_r;
      skipEqual_nxt     = skipEqual_r;

      if (s_axi_awvalid && awReady_r) begin
         awHeld_nxt = 1'b1;
         awAddr_nxt = s_axi_awaddr[ADDR_W-1:0];
      end
      if (s_axi_wvalid && wReady_r) begin
         wHeld_nxt = 1'b1;
         wData_nxt = s_axi_wdata;
         wStrb_nxt = s_axi_wstrb;
      end
      if (s_axi_arvalid && arReady_r) begin
         arHeld_nxt = 1'b1;
         arAddr_nxt = s_axi_araddr[ADDR_W-1:0];
      end
      if (bValid_r && s_axi_bready) begin
         bValid_nxt = 1'b0;
      end
      if (rValid_r && s_axi_rready) begin
         rValid_nxt = 1'b0;
      end

      // A pending write goes first, so a read and a write of the window
      // never claim the same transfer index in one cycle.
      doWrite     = awHeld_r && wHeld_r && !bValid_r;
      doRead      = arHeld_r && !rValid_r && !doWrite;
      writeTarget = resolve_target(awAddr_r, burstStart_r, xferIndex_r);
      readTarget  = resolve_target(arAddr_r, burstStart_r, xferIndex_r);

      if (doWrite) begin
         awHeld_nxt = 1'b0;
         wHeld_nxt  = 1'b0;
         bValid_nxt = 1'b1;
         bResp_nxt  = RESP_OKAY;
         if (wStrb_r != FULL_STROBE) begin
            bResp_nxt = RESP_SLVERR;
         end else begin
            case (writeTarget)
               CH3_VALUE_OFS: begin
                  if (!channel3InputMode &&
                      !(skipEqual_r && wData_r[VAL_W-1:0] == ch3Value_r)) begin
                     ch3Value_nxt = wData_r[VAL_W-1:0];
                     if (!shadowEnable) begin
                        activeCompare_nxt = wData_r[VAL_W-1:0];
                     end
                  end
               end
               INPUT_REMAP_OFS: begin
                  inputSource_nxt = wData_r[SOURCE_MSB:SOURCE_LSB];
               end
               DMA_CFG_OFS: begin
                  burstStart_nxt = wData_r[START_MSB:START_LSB];
                  // Lengths above the limit are clamped so the index wrap stays bounded.
                  if (wData_r[LENGTH_MSB:LENGTH_LSB] > LENGTH_MAX) begin
                     burstLength_nxt = LENGTH_MAX;
                  end else begin
                     burstLength_nxt = wData_r[LENGTH_MSB:LENGTH_LSB];
                  end
                  xferIndex_nxt = 5'h00;
               end
               FILTER_CFG_OFS: begin
                  skipEqual_nxt = wData_r[SKIP_BIT];
               end
               default: begin
                  bResp_nxt = RESP_SLVERR;
               end
            endcase
         end
         if (awAddr_r == DMA_WINDOW_OFS) begin
            if (xferIndex_r >= burstLength_r) begin
               xferIndex_nxt = 5'h00;
            end else begin
               xferIndex_nxt = xferIndex_r + 5'h01;
            end
         end
      end

      if (doRead) begin
         arHeld_nxt = 1'b0;
         rValid_nxt = 1'b1;
         rResp_nxt  = RESP_OKAY;
         rData_nxt  = REG_RESET;
         case (readTarget)
            CH3_VALUE_OFS: begin
               rData_nxt[VAL_W-1:0] = ch3Value_r;
            end
            INPUT_REMAP_OFS: begin
               rData_nxt[SOURCE_MSB:SOURCE_LSB] = inputSource_r;
            end
            DMA_CFG_OFS: begin
               rData_nxt[START_MSB:START_LSB]   = burstStart_r;
               rData_nxt[LENGTH_MSB:LENGTH_LSB] = burstLength_r;
            end
            FILTER_CFG_OFS: begin
               rData_nxt[SKIP_BIT] = skipEqual_r;
            end
            default: begin
               rResp_nxt = RESP_SLVERR;
            end
         endcase
         if (arAddr_r == DMA_WINDOW_OFS) begin
            if (xferIndex_r >= burstLength_r) begin
               xferIndex_nxt = 5'h00;
            end else begin
               xferIndex_nxt = xferIndex_r + 5'h01;
            end
         end
      end

      if (channel3InputMode && captureEvent) begin
         ch3Value_nxt = counterValue;
      end
      // The refresh takes the value being written in the same cycle so it is not lost.
      if (!channel3InputMode && shadowEnable && updateEvent) begin
         activeCompare_nxt = ch3Value_nxt;
      end
      compareMatch_nxt = !channel3InputMode && (counterValue == activeCompare_r);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         awHeld_r        <= 1'b0;
         awAddr_r        <= 8'h00;
         wHeld_r         <= 1'b0;
         wData_r         <= REG_RESET;
         wStrb_r         <= 4'h0;
         arHeld_r        <= 1'b0;
         arAddr_r        <= 8'h00;
         awReady_r       <= 1'b1;
         wReady_r        <= 1'b1;
         arReady_r       <= 1'b1;
         bValid_r        <= 1'b0;
         bResp_r         <= RESP_OKAY;
         rValid_r        <= 1'b0;
         rResp_r         <= RESP_OKAY;
         rData_r         <= REG_RESET;
         ch3Value_r      <= 16'h0000;
         activeCompare_r <= 16'h0000;
         burstStart_r    <= 5'h00;
         burstLength_r   <= 5'h00;
         xferIndex_r     <= 5'h00;
         inputSource_r   <= SRC_PIN;
         skipEqual_r     <= 1'b0;
         compareMatch_r  <= 1'b0;
      end else begin
         awHeld_r        <= awHeld_nxt;
         awAddr_r        <= awAddr_nxt;
         wHeld_r         <= wHeld_nxt;
         wData_r         <= wData_nxt;
         wStrb_r         <= wStrb_nxt;
         arHeld_r        <= arHeld_nxt;
         arAddr_r        <= arAddr_nxt;
         awReady_r       <= !awHeld_nxt;
         wReady_r        <= !wHeld_nxt;
         arReady_r       <= !arHeld_nxt;
         bValid_r        <= bValid_nxt;
         bResp_r         <= bResp_nxt;
         rValid_r        <= rValid_nxt;
         rResp_r         <= rResp_nxt;
         rData_r         <= rData_nxt;
         ch3Value_r      <= ch3Value_nxt;
         activeCompare_r <= activeCompare_nxt;
         burstStart_r    <= burstStart_nxt;
         burstLength_r   <= burstLength_nxt;
         xferIndex_r     <= xferIndex_nxt;
         inputSource_r   <= inputSource_nxt;
         skipEqual_r     <= skipEqual_nxt;
         compareMatch_r  <= compareMatch_nxt;
      end
   end

   assign srcRaw[SRC_PIN]          = pinInputChannelZero;
   assign srcRaw[SRC_LOW_XTAL]     = lowSpeedCrystalClock;
   assign srcRaw[SRC_HIGH_XTAL128] = highSpeedCrystalDiv128;
   assign srcRaw[SRC_CLK_OUT_SEL]  = clockOutputZeroSelection;

   // The sources are asynchronous; a level is accepted only once the last two
   // stages agree, which costs four cycles of latency but filters glitches.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SOURCES; gi++) begin : gSrc
         logic [2:0] syncStage_r;
         logic       stable_r;
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               syncStage_r <= 3'h0;
               stable_r    <= 1'b0;
            end else begin
               syncStage_r <= {syncStage_r[1:0], srcRaw[gi]};
               if (syncStage_r[1] == syncStage_r[2]) begin
                  stable_r <= syncStage_r[2];
               end
            end
         end
         assign srcStable[gi] = stable_r;
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         channel0Input_r <= 1'b0;
      end else begin
         channel0Input_r <= srcStable[inputSource_r];
      end
   end

   assign s_axi_awready = awReady_r;
   assign s_axi_wready  = wReady_r;
   assign s_axi_arready = arReady_r;
   assign s_axi_bvalid  = bValid_r;
   assign s_axi_bresp   = bResp_r;
   assign s_axi_rvalid  = rValid_r;
   assign s_axi_rresp   = rResp_r;
   assign s_axi_rdata   = rData_r;
   assign compareValue  = activeCompare_r;
   assign compareMatch  = compareMatch_r;
   assign channel0Input = channel0Input_r;

endmodule

// ### verif/tdbc_bus_master.sv
`timescale 1ns/10ps
module tdbc_bus_master
   import tdbc_pkg::*;
(
   input  wire logic        clk,
   output logic [31:0]      s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [31:0]      s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   assign s_axi_wstrb = FULL_STROBE;
   initial begin
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
   end
   // Released payloads are inverted so a design that samples them late sees garbage.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~{24'h0, a};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
         if (s_axi_bvalid && s_axi_bready) break;
         // Ready follows the answer by one cycle, so a response left waiting is exercised.
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 64) tdbc_regs_tb.hang();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
      int n;
      @(posedge clk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~{24'h0, a};
         end
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      q = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 64) tdbc_regs_tb.hang();
   endtask
endmodule

// ### verif/tdbc_regs_sva.sv
`timescale 1ns/10ps
module tdbc_regs_sva
   import tdbc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   input  wire logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        channel3InputMode,
   input  wire logic        shadowEnable,
   input  wire logic        updateEvent,
   input  wire logic [15:0] counterValue,
   input  wire logic [15:0] compareValue,
   input  wire logic        compareMatch
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence writeTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence readTaken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before it was taken");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before it was taken");
   a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_write_answered: assert property (writeTaken |-> ##[1:3] s_axi_bvalid)
      else $error("write not answered in time");
   a_read_answered: assert property (readTaken |-> ##[1:3] s_axi_rvalid)
      else $error("read not answered in time");
   a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("write address accepted while busy");
   a_match_flag: assert property (!channel3InputMode && counterValue == compareValue |=> compareMatch)
      else $error("compare match missed");
   a_match_input_off: assert property (channel3InputMode |=> !compareMatch)
      else $error("compare match raised in capture mode");
   a_shadow_hold: assert property (shadowEnable && $past(shadowEnable) && !updateEvent && !channel3InputMode
      |=> $stable(compareValue))
      else $error("active compare changed without update event");
endmodule
bind tdbc_regs tdbc_regs_sva u_sva (.*);

// ### verif/tdbc_regs_tb.sv
`timescale 1ns/10ps
module tdbc_regs_tb
   import tdbc_pkg::*;
;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] wr; logic [31:0] q; logic [1:0] rr;} tdbc_row_t;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, compareMatch, channel0Input;
   logic        channel3InputMode = 1'b0, shadowEnable = 1'b0, updateEvent = 1'b0, captureEvent = 1'b0;
   logic        pinInputChannelZero = 1'b0, lowSpeedCrystalClock = 1'b0;
   logic        highSpeedCrystalDiv128 = 1'b0, clockOutputZeroSelection = 1'b0;
   logic [15:0] counterValue = 16'h0000, compareValue;
   logic [7:0]  resetAddrs [4] = '{CH3_VALUE_OFS, INPUT_REMAP_OFS, DMA_CFG_OFS, FILTER_CFG_OFS};
   tdbc_row_t   rows [5] = '{
      '{8'h40, 32'h0000beef, RESP_OKAY, 32'h0000beef, RESP_OKAY},
      '{8'h50, 32'h00000003, RESP_OKAY, 32'h00000003, RESP_OKAY},
      '{8'he0, 32'h00001105, RESP_OKAY, 32'h00001105, RESP_OKAY},
      '{8'hfc, 32'h00000002, RESP_OKAY, 32'h00000002, RESP_OKAY},
      '{8'h44, 32'h00000001, RESP_SLVERR, 32'h00000000, RESP_SLVERR}};
   int errors = 0;
   int checked = 0;
   always #50 clk = ~clk;
   tdbc_regs DUT (.*);
   tdbc_bus_master bus (.*);
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic hang;
      errors++;
      $display("[FAIL] %0t bus handshake timed out", $time);
      tally_and_finish();
   endtask
   task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      bus.wr(a, d, r);
      check({30'h0, r}, {30'h0, er}, "write response");
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] eq, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0]  r;
      bus.rd(a, q, r);
      check(q, eq, "read data");
      check({30'h0, r}, {30'h0, er}, "read response");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      foreach (resetAddrs[i]) rchk(resetAddrs[i], 32'h0, RESP_OKAY);
      foreach (rows[i]) begin
         wchk(rows[i].a, rows[i].d, rows[i].wr);
         rchk(rows[i].a, rows[i].q, rows[i].rr);
      end
      check({16'h0, compareValue}, 32'h0000beef, "compare value");
      counterValue <= 16'hbeef;
      repeat (2) @(posedge clk);
      check({31'h0, compareMatch}, 32'h1, "compare match");
      // Each source in turn is driven opposite to the other three, so a wrong route shows.
      for (int s = 0; s < NUM_SOURCES; s++) begin
         wchk(INPUT_REMAP_OFS, 32'(s), RESP_OKAY);
         {clockOutputZeroSelection, highSpeedCrystalDiv128, lowSpeedCrystalClock, pinInputChannelZero} <= 4'h1 << s;
         repeat (8) @(posedge clk);
         check({31'h0, channel0Input}, 32'h1, "selected source high");
         {clockOutputZeroSelection, highSpeedCrystalDiv128, lowSpeedCrystalClock, pinInputChannelZero} <= ~(4'h1 << s);
         repeat (8) @(posedge clk);
         check({31'h0, channel0Input}, 32'h0, "selected source low");
      end
      wchk(DMA_CFG_OFS, 32'h00000410, RESP_OKAY);
      for (int i = 0; i < 5; i++) wchk(DMA_WINDOW_OFS, 32'h1, (i % 4 == 0) ? RESP_OKAY : RESP_SLVERR);
      rchk(CH3_VALUE_OFS, 32'h1, RESP_OKAY);
      rchk(INPUT_REMAP_OFS, 32'h1, RESP_OKAY);
      rchk(DMA_WINDOW_OFS, 32'h1, RESP_OKAY);
      rchk(DMA_WINDOW_OFS, 32'h0, RESP_SLVERR);
      shadowEnable <= 1'b1;
      wchk(CH3_VALUE_OFS, 32'h00000077, RESP_OKAY);
      repeat (3) @(posedge clk);
      check({16'h0, compareValue}, 32'h1, "compare before update");
      // With the shadow off a taken write would reach the compare at once, so only the skip keeps it at 1.
      shadowEnable <= 1'b0;
      wchk(CH3_VALUE_OFS, 32'h00000077, RESP_OKAY);
      repeat (3) @(posedge clk);
      check({16'h0, compareValue}, 32'h1, "equal write skipped");
      shadowEnable <= 1'b1;
      updateEvent <= 1'b1;
      @(posedge clk);
      updateEvent <= 1'b0;
      repeat (2) @(posedge clk);
      check({16'h0, compareValue}, 32'h77, "compare after update");
      shadowEnable <= 1'b0;
      channel3InputMode <= 1'b1;
      counterValue <= 16'h1357;
      captureEvent <= 1'b1;
      @(posedge clk);
      captureEvent <= 1'b0;
      rchk(CH3_VALUE_OFS, 32'h1357, RESP_OKAY);
      wchk(CH3_VALUE_OFS, 32'h0abc, RESP_OKAY);
      rchk(CH3_VALUE_OFS, 32'h1357, RESP_OKAY);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      check({16'h0, compareValue}, 32'h0, "compare value in reset");
      check({31'h0, channel0Input}, 32'h0, "channel 0 input in reset");
      rst_b <= 1'b1;
      foreach (resetAddrs[i]) rchk(resetAddrs[i], 32'h0, RESP_OKAY);
      tally_and_finish();
   end
endmodule
